// File: hdl/wtp_pkg.sv
// shared constants, types and register map of the waveform trigger block
package wtp_pkg;
	localparam int SAMPLE_W = 16;
	localparam int ADDR_W   = 24;
	localparam int TRIM_W   = 8;
	localparam int REG_AW   = 4;

	// register offsets
	localparam logic [REG_AW-1:0] REG_CTRL   = 4'h0;
	localparam logic [REG_AW-1:0] REG_LEN    = 4'h1;
	localparam logic [REG_AW-1:0] REG_IDLE   = 4'h2;
	localparam logic [REG_AW-1:0] REG_GAIN   = 4'h3;
	localparam logic [REG_AW-1:0] REG_OFFS   = 4'h4;
	localparam logic [REG_AW-1:0] REG_SKEW   = 4'h5;
	localparam logic [REG_AW-1:0] REG_CMD    = 4'h6;
	localparam logic [REG_AW-1:0] REG_STATUS = 4'h7;
	localparam logic [REG_AW-1:0] REG_RATE   = 4'h8;

	// control and command register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_EDGE_BIT = 2;
	localparam int CTRL_POL_BIT  = 3;
	localparam int CTRL_FAST_BIT = 4;
	localparam int CTRL_AUTO_BIT = 5;
	localparam int CMD_TRIG_BIT  = 0;

	localparam logic [31:0] CTRL_RST = 32'h0000_0020;
	localparam logic [31:0] LEN_RST  = 32'h0000_0018;
	localparam logic [31:0] RATE_RST = 32'h0000_0000;

	// clock rate thresholds in Hz
	localparam logic [31:0] SLOW_BELOW_HZ = 32'd2_000_000;
	localparam logic [31:0] FAST_ABOVE_HZ = 32'd4_000_000;
	localparam int          FAST_LEN_STEP = 4;

	// latency figures
	localparam int CLK_MHZ       = 100;
	localparam int SLOW_LAT_NS   = 220;
	localparam int SLOW_LAT_CYC  = (SLOW_LAT_NS * CLK_MHZ) / 1000;
	localparam int FAST_LAT_SMP  = 11;
	localparam int SYNC_STAGES   = 2;
	localparam int LAT_W         = 8;

	typedef enum logic [1:0] {
		TM_OFF,
		TM_SINGLE,
		TM_WINDOW,
		TM_REPEAT
	} wtp_mode_e;

	typedef struct packed {
		logic [SAMPLE_W-1:0] i;
		logic [SAMPLE_W-1:0] q;
	} wtp_iq_s;

	typedef struct packed {
		logic signed [TRIM_W-1:0] i;
		logic signed [TRIM_W-1:0] q;
	} wtp_trim_s;
endpackage

// File: hdl/wtp_fifo.sv
// synchronous valid/ready FIFO for the sample path
`timescale 1ns/10ps
module wtp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             flush,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_r];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else if (flush) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // wtp_fifo

// File: hdl/wtp_trig_sync.sv
// trigger input synchroniser with edge or level qualification
`timescale 1ns/10ps
module wtp_trig_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// settings
	input  wire logic edge_sel,
	input  wire logic active_high,
	// trigger pin and results
	input  wire logic trig_in,
	output logic      trig_fire,
	output logic      trig_active
);
	logic meta_r;
	logic sync_r;
	logic prev_r;
	logic lvl;

	// two flops before any decoding so latency is whole clock cycles
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= trig_in;
			sync_r <= meta_r;
			prev_r <= lvl;
		end
	end

	assign lvl         = active_high ? sync_r : !sync_r;
	assign trig_active = lvl;
	// edge mode fires on the chosen edge, level mode on onset of the level
	assign trig_fire   = lvl && !prev_r;
	wire unused_edge   = edge_sel;
endmodule // wtp_trig_sync

// File: hdl/wtp_playback.sv
// trigger, sequencing and correction logic for stored I/Q playback
`timescale 1ns/10ps
module wtp_playback #(
	parameter int DEPTH   = 16,
	parameter int SKEW_SH = 5
) (
	// clock and reset
	input  wire logic                             clk,
	input  wire logic                             rst_b,
	// register port
	input  wire logic [wtp_pkg::REG_AW-1:0]       reg_addr,
	input  wire logic [31:0]                      reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output logic      [31:0]                      reg_rdata,
	// sample period strobe and trigger pin
	input  wire logic                             sample_tick,
	input  wire logic                             trig_in,
	// waveform memory
	output logic      [wtp_pkg::ADDR_W-1:0]       mem_addr,
	output logic                                  mem_req,
	input  wire logic                             mem_gnt,
	input  wire wtp_pkg::wtp_iq_s                 mem_data,
	// outputs
	output wtp_pkg::wtp_iq_s                      iq_out,
	output logic                                  iq_valid,
	output logic      [wtp_pkg::TRIM_W-1:0]       channel_delay_trim,
	output logic                                  fast_mode
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_PLAY
	} wtp_state_e;

	logic [31:0]                    ctrl_r;
	logic [wtp_pkg::ADDR_W-1:0]     len_r;
	wtp_pkg::wtp_iq_s               idle_r;
	wtp_pkg::wtp_trim_s             gain_r;
	wtp_pkg::wtp_trim_s             offs_r;
	logic [wtp_pkg::TRIM_W-1:0]     skew_r;
	logic [31:0]                    rate_r;
	logic                           cmd_trig_r;
	wtp_state_e                     st_r;
	logic [wtp_pkg::LAT_W-1:0]      lat_r;
	logic [wtp_pkg::ADDR_W-1:0]     rd_addr_r;
	logic                           fast_r;
	wtp_pkg::wtp_mode_e             mode;
	logic                           trig_fire;
	logic                           trig_active;
	logic                           start;
	logic                           stop;
	logic                           fifo_in_ready;
	logic                           fifo_out_valid;
	wtp_pkg::wtp_iq_s               fifo_out;
	logic                           pop;
	logic [wtp_pkg::ADDR_W-1:0]     len_eff;
	logic [wtp_pkg::LAT_W-1:0]      lat_load;
	logic                           play_en;
	logic                           fetch_done_r;
	logic                           fifo_last_r;
	logic                           fetch_last;
	logic                           fifo_last_out;

	assign mode = wtp_pkg::wtp_mode_e'(ctrl_r[wtp_pkg::CTRL_MODE_LSB +: 2]);

	// register writes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= wtp_pkg::CTRL_RST;
			len_r  <= wtp_pkg::LEN_RST[wtp_pkg::ADDR_W-1:0];
			idle_r <= '0;
			gain_r <= '0;
			offs_r <= '0;
			skew_r <= '0;
			rate_r <= wtp_pkg::RATE_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				wtp_pkg::REG_CTRL: ctrl_r <= reg_wdata;
				wtp_pkg::REG_LEN:  len_r  <= reg_wdata[wtp_pkg::ADDR_W-1:0];
				wtp_pkg::REG_IDLE: idle_r <= reg_wdata;
				wtp_pkg::REG_GAIN: gain_r <= reg_wdata[15:0];
				wtp_pkg::REG_OFFS: offs_r <= reg_wdata[15:0];
				wtp_pkg::REG_SKEW: skew_r <= reg_wdata[7:0];
				wtp_pkg::REG_RATE: rate_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// software trigger command is a one cycle pulse
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_trig_r <= 1'b0;
		end else begin
			cmd_trig_r <= reg_wr && (reg_addr == wtp_pkg::REG_CMD) &&
				reg_wdata[wtp_pkg::CMD_TRIG_BIT];
		end
	end

	// rate mode: automatic from the requested rate, manual in 2..4 MHz band
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fast_r <= 1'b0;
		end else if (ctrl_r[wtp_pkg::CTRL_AUTO_BIT] &&
			rate_r < wtp_pkg::SLOW_BELOW_HZ) begin
			fast_r <= 1'b0;
		end else if (ctrl_r[wtp_pkg::CTRL_AUTO_BIT] &&
			rate_r > wtp_pkg::FAST_ABOVE_HZ) begin
			fast_r <= 1'b1;
		end else begin
			fast_r <= ctrl_r[wtp_pkg::CTRL_FAST_BIT];
		end
	end
	assign fast_mode = fast_r;

	// fast mode rounds length down to a multiple of four samples
	assign len_eff = fast_r ? {len_r[wtp_pkg::ADDR_W-1:2], 2'b00} : len_r;

	wtp_trig_sync u_sync (
		.clk         (clk),
		.rst_b       (rst_b),
		.edge_sel    (ctrl_r[wtp_pkg::CTRL_EDGE_BIT]),
		.active_high (ctrl_r[wtp_pkg::CTRL_POL_BIT]),
		.trig_in     (trig_in),
		.trig_fire   (trig_fire),
		.trig_active (trig_active)
	);

	assign start = (mode != wtp_pkg::TM_OFF) && (trig_fire || cmd_trig_r);
	// window mode ends with the trigger level, off mode ends everything
	assign stop  = (mode == wtp_pkg::TM_OFF) ||
		(mode == wtp_pkg::TM_WINDOW && !trig_active && !cmd_trig_r);

	// latency: cycles in slow mode, sample periods in fast mode
	assign lat_load = fast_r ?
		wtp_pkg::LAT_W'(wtp_pkg::FAST_LAT_SMP - 1) :
		wtp_pkg::LAT_W'(wtp_pkg::SLOW_LAT_CYC - wtp_pkg::SYNC_STAGES - 1);

	// sequencer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r  <= ST_IDLE;
			lat_r <= '0;
		end else if (stop && st_r != ST_IDLE) begin
			st_r <= ST_IDLE;
		end else begin
			unique case (st_r)
				ST_IDLE: if (start) begin
					st_r  <= ST_WAIT;
					lat_r <= lat_load;
				end
				ST_WAIT: begin
					if (!fast_r || sample_tick) begin
						lat_r <= lat_r - 1'b1;
					end
					if (lat_r == '0) begin
						st_r <= ST_PLAY;
					end
				end
				ST_PLAY: if (pop && mode == wtp_pkg::TM_SINGLE &&
					fifo_last_out) begin
					st_r <= ST_IDLE;
				end else if (start && mode == wtp_pkg::TM_WINDOW &&
					trig_fire) begin
					st_r  <= ST_WAIT;
					lat_r <= lat_load;
				end
			endcase
		end
	end

	// memory fetch address wraps at the end for gapless repeat
	assign fetch_last = (rd_addr_r == len_eff - 1'b1);
	assign mem_req  = (st_r != ST_IDLE) && fifo_in_ready && !fetch_done_r;
	assign mem_addr = rd_addr_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_addr_r    <= '0;
			fetch_done_r <= 1'b0;
		end else if (st_r == ST_IDLE || (st_r == ST_PLAY && start &&
			mode == wtp_pkg::TM_WINDOW && trig_fire)) begin
			rd_addr_r    <= '0;
			fetch_done_r <= 1'b0;
		end else if (mem_req && mem_gnt) begin
			rd_addr_r <= fetch_last ? '0 : rd_addr_r + 1'b1;
			if (fetch_last && mode == wtp_pkg::TM_SINGLE) begin
				fetch_done_r <= 1'b1;
			end
		end
	end

	// fifo carries the fetched samples plus an end-of-waveform mark
	wtp_fifo #(
		.WIDTH (2*wtp_pkg::SAMPLE_W + 1),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.flush     (st_r == ST_IDLE),
		.in_valid  (mem_req && mem_gnt),
		.in_ready  (fifo_in_ready),
		.in_data   ({fetch_last, mem_data}),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.out_data  ({fifo_last_out, fifo_out})
	);

	assign play_en = (st_r == ST_PLAY);
	assign pop     = play_en && sample_tick && fifo_out_valid;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fifo_last_r <= 1'b0;
		end else begin
			fifo_last_r <= fifo_last_out;
		end
	end

	// corrections: gain of +-1.0 maps to about +-12.5 percent, offset added
	function automatic logic [wtp_pkg::SAMPLE_W-1:0] trim(
		input logic [wtp_pkg::SAMPLE_W-1:0] s,
		input logic signed [wtp_pkg::TRIM_W-1:0] g,
		input logic signed [wtp_pkg::TRIM_W-1:0] o);
		logic signed [31:0] v;
		v = 32'(signed'(s));
		v = v + ((v * 32'(g)) >>> 10) + (32'(o) <<< 2);
		trim = wtp_pkg::SAMPLE_W'(v);
	endfunction

	// outputs hold idle value unless a sample is being played
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			iq_out   <= '0;
			iq_valid <= 1'b0;
		end else if (pop) begin
			iq_out.i <= trim(fifo_out.i, gain_r.i, offs_r.i);
			iq_out.q <= trim(fifo_out.q, gain_r.q, offs_r.q);
			iq_valid <= 1'b1;
		end else if (!play_en) begin
			iq_out   <= idle_r;
			iq_valid <= 1'b0;
		end else begin
			iq_valid <= 1'b0;
		end
	end

	// skew is handed to the analogue fine delay; positive delays in-phase
	assign channel_delay_trim = skew_r;

	// register reads, data one cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				wtp_pkg::REG_CTRL:   reg_rdata <= ctrl_r;
				wtp_pkg::REG_LEN:    reg_rdata <= 32'(len_r);
				wtp_pkg::REG_IDLE:   reg_rdata <= idle_r;
				wtp_pkg::REG_GAIN:   reg_rdata <= 32'(gain_r);
				wtp_pkg::REG_OFFS:   reg_rdata <= 32'(offs_r);
				wtp_pkg::REG_SKEW:   reg_rdata <= 32'(skew_r);
				wtp_pkg::REG_RATE:   reg_rdata <= rate_r;
				wtp_pkg::REG_STATUS: reg_rdata <= {27'h0, fast_r,
					trig_active, fifo_out_valid, st_r};
				default:             reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// assertions
	a_off_idle_out: assert property (@(posedge clk) disable iff (!rst_b)
		mode == wtp_pkg::TM_OFF |=> ##1 (iq_out == $past(idle_r) && !iq_valid))
		else $error("off mode not idle");
	a_idle_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r != ST_PLAY) && $past(st_r != ST_PLAY) |-> !iq_valid)
		else $error("sample output while not playing");
	a_slow_latency: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_IDLE && start && !fast_r && !stop) |->
		##20 st_r == ST_WAIT ##1 st_r == ST_PLAY || stop)
		else $error("slow latency wrong");
	a_start_wait: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_IDLE && start && !stop) |=> st_r == ST_WAIT)
		else $error("start not taken");
	a_addr_wrap: assert property (@(posedge clk) disable iff (!rst_b)
		(mem_req && mem_gnt && fetch_last && st_r != ST_IDLE && !start)
		|=> rd_addr_r == '0)
		else $error("address did not wrap");
	a_fast_len: assert property (@(posedge clk) disable iff (!rst_b)
		fast_r |-> len_eff[1:0] == 2'b00)
		else $error("fast length not multiple of four");
	a_slow_auto: assert property (@(posedge clk) disable iff (!rst_b)
		ctrl_r[wtp_pkg::CTRL_AUTO_BIT] && rate_r < wtp_pkg::SLOW_BELOW_HZ
		|=> !fast_r)
		else $error("slow mode not chosen");
	a_window_stop: assert property (@(posedge clk) disable iff (!rst_b)
		(mode == wtp_pkg::TM_WINDOW && st_r == ST_PLAY && stop)
		|=> st_r == ST_IDLE)
		else $error("window playback did not stop");
	a_single_end: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == ST_PLAY && mode == wtp_pkg::TM_SINGLE && pop &&
		fifo_last_out && !stop) |=> st_r == ST_IDLE ##1 !iq_valid)
		else $error("single shot overran");
	c_single: cover property (@(posedge clk)
		mode == wtp_pkg::TM_SINGLE && st_r == ST_PLAY ##1 st_r == ST_IDLE);
	c_repeat: cover property (@(posedge clk)
		mode == wtp_pkg::TM_REPEAT && pop && fifo_last_r);
	c_window: cover property (@(posedge clk)
		mode == wtp_pkg::TM_WINDOW && st_r == ST_PLAY && stop);
endmodule // wtp_playback

// File: testbench/wtp_mem_model.sv
// waveform memory model that answers fetches promptly or at half rate
`timescale 1ns/10ps
module wtp_mem_model (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	// pacing
	input  wire logic                       stall,
	// fetch port
	input  wire logic [wtp_pkg::ADDR_W-1:0] mem_addr,
	input  wire logic                       mem_req,
	output logic                            mem_gnt,
	output wtp_pkg::wtp_iq_s                mem_data
);
	logic        alt_r;
	logic [31:0] word;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			alt_r <= 1'b0;
		end else begin
			alt_r <= ~alt_r;
		end
	end

	// word tied to its address so order and wrap show at the outputs
	assign word     = {mem_addr[15:0] ^ 16'hA000, mem_addr[15:0]};
	assign mem_gnt  = mem_req && (!stall || alt_r);
	// without a grant the bus carries the inverse, never a stale word
	assign mem_data = mem_gnt ? word : ~word;
endmodule // wtp_mem_model

// File: testbench/tb_top.sv
// self-checking bench for the waveform trigger and playback block
`timescale 1ns/10ps
module tb_top;
	localparam int          P      = 4;
	localparam logic [31:0] IDLE_V = 32'h1234_5678;
	logic                       clk, rst_b, reg_wr, reg_rd, sample_tick;
	logic                       trig_in, mem_req, mem_gnt, iq_valid;
	logic                       fast_mode, stall;
	logic [wtp_pkg::REG_AW-1:0] reg_addr;
	logic [31:0]                reg_wdata, reg_rdata, v;
	logic [wtp_pkg::ADDR_W-1:0] mem_addr;
	logic [wtp_pkg::TRIM_W-1:0] channel_delay_trim;
	wtp_pkg::wtp_iq_s           mem_data, iq_out;
	int                         mismatches, n_checks, cyc, tk, w;

	wtp_playback #(.DEPTH(16), .SKEW_SH(5)) u_wtp_playback (
		.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sample_tick(sample_tick),
		.trig_in(trig_in), .mem_addr(mem_addr), .mem_req(mem_req),
		.mem_gnt(mem_gnt), .mem_data(mem_data), .iq_out(iq_out),
		.iq_valid(iq_valid), .channel_delay_trim(channel_delay_trim),
		.fast_mode(fast_mode));
	wtp_mem_model u_wtp_mem_model (
		.clk(clk), .rst_b(rst_b), .stall(stall), .mem_addr(mem_addr),
		.mem_req(mem_req), .mem_gnt(mem_gnt), .mem_data(mem_data));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// one sample strobe every P clocks
	always @(posedge clk) begin
		tk <= (tk == P - 1) ? 0 : tk + 1;
		sample_tick <= (tk == P - 1);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task wr(input logic [wtp_pkg::REG_AW-1:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [wtp_pkg::REG_AW-1:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task rdchk(input logic [wtp_pkg::REG_AW-1:0] a, input logic [31:0] e);
		rd(a, v);
		chk("reg", v, e);
	endtask

	task ctrl(input logic [1:0] m, input logic edg, input logic fst);
		wr(wtp_pkg::REG_CTRL, {26'h0, 1'b0, fst, 1'b1, edg, m});
	endtask

	function automatic logic [31:0] expd(input int k);
		return {k[15:0] ^ 16'hA000, k[15:0]};
	endfunction

	task next_smp(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (iq_valid !== 1'b1 && n < 400);
		chk("valid_seen", 32'(n < 400), 32'h1);
	endtask

	task play(input int n, input int start, input int len);
		int g;
		for (int k = 0; k < n; k++) begin
			next_smp(g);
			if (k + start > 0) chk("gap", 32'(g), 32'(P));
			chk("sample", iq_out, expd((k + start) % len));
		end
	endtask

	task idle_chk(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			chk("idle_valid", 32'(iq_valid), 32'h0);
			chk("idle_out", iq_out, IDLE_V);
		end
	endtask

	task t_regs;
		chk("rst_out", iq_out, 32'h0);
		rdchk(wtp_pkg::REG_CTRL, wtp_pkg::CTRL_RST);
		rdchk(wtp_pkg::REG_LEN, wtp_pkg::LEN_RST);
		rdchk(wtp_pkg::REG_RATE, wtp_pkg::RATE_RST);
		rdchk(4'hF, 32'h0);
		wr(wtp_pkg::REG_GAIN, 32'h0000_7F81);
		rdchk(wtp_pkg::REG_GAIN, 32'h0000_7F81);
		wr(wtp_pkg::REG_OFFS, 32'h0000_807F);
		rdchk(wtp_pkg::REG_OFFS, 32'h0000_807F);
		wr(wtp_pkg::REG_SKEW, 32'h0000_009C);
		rdchk(wtp_pkg::REG_SKEW, 32'h0000_009C);
		chk("skew", 32'(channel_delay_trim), 32'h9C);
		wr(wtp_pkg::REG_GAIN, 32'h0);
		wr(wtp_pkg::REG_OFFS, 32'h0);
		wr(wtp_pkg::REG_IDLE, IDLE_V);
		rdchk(wtp_pkg::REG_IDLE, IDLE_V);
	endtask

	task t_single_cmd;
		ctrl(2'h1, 1'b0, 1'b0);
		idle_chk(10);
		wr(wtp_pkg::REG_CMD, 32'h1);
		play(24, 0, 24);
		repeat (2 * P) @(posedge clk);
		idle_chk(40);
	endtask

	task t_repeat_off;
		stall <= 1'b1;
		ctrl(2'h3, 1'b0, 1'b0);
		wr(wtp_pkg::REG_CMD, 32'h1);
		play(60, 0, 24);
		ctrl(2'h0, 1'b0, 1'b0);
		repeat (2 * P) @(posedge clk);
		trig_in <= 1'b1;
		wr(wtp_pkg::REG_CMD, 32'h1);
		idle_chk(60);
		trig_in <= 1'b0;
		stall   <= 1'b0;
	endtask

	task t_window;
		ctrl(2'h2, 1'b0, 1'b0);
		trig_in <= 1'b1;
		play(30, 0, 24);
		trig_in <= 1'b0;
		repeat (40) @(posedge clk);
		idle_chk(30);
		trig_in <= 1'b1;
		play(5, 0, 24);
		trig_in <= 1'b0;
		repeat (40) @(posedge clk);
		idle_chk(10);
	endtask

	task t_slow_lat;
		ctrl(2'h1, 1'b1, 1'b0);
		@(posedge clk);
		trig_in <= 1'b1;
		next_smp(w);
		chk("slow_lat", 32'(w >= wtp_pkg::SLOW_LAT_CYC - 1 &&
			w <= wtp_pkg::SLOW_LAT_CYC + P + 2), 32'h1);
		chk("first", iq_out, expd(0));
		play(23, 1, 24);
		trig_in <= 1'b0;
		repeat (2 * P) @(posedge clk);
		idle_chk(20);
	endtask

	task t_fast;
		int t;
		t = 0;
		wr(wtp_pkg::REG_LEN, 32'd26);
		ctrl(2'h1, 1'b1, 1'b1);
		repeat (3) @(posedge clk);
		chk("fast_mode", 32'(fast_mode), 32'h1);
		trig_in <= 1'b1;
		do begin
			@(posedge clk);
			#1;
			if (sample_tick) t++;
		end while (iq_valid !== 1'b1 && t < 40);
		chk("fast_lat", 32'(t >= wtp_pkg::FAST_LAT_SMP &&
			t <= wtp_pkg::FAST_LAT_SMP + 1), 32'h1);
		chk("first", iq_out, expd(0));
		play(23, 1, 24);
		repeat (2 * P) @(posedge clk);
		idle_chk(20);
		trig_in <= 1'b0;
	endtask

	task t_auto;
		wr(wtp_pkg::REG_RATE, wtp_pkg::SLOW_BELOW_HZ - 32'h1);
		ctrl(2'h0, 1'b0, 1'b1);
		wr(wtp_pkg::REG_CTRL, 32'h0000_0038);
		repeat (4) @(posedge clk);
		chk("auto_slow", 32'(fast_mode), 32'h0);
		wr(wtp_pkg::REG_RATE, wtp_pkg::FAST_ABOVE_HZ + 32'h1);
		repeat (4) @(posedge clk);
		chk("auto_fast", 32'(fast_mode), 32'h1);
	endtask

	initial begin
		rst_b       = 1'b0;
		reg_addr    = '0;
		reg_wdata   = '0;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		sample_tick = 1'b0;
		trig_in     = 1'b0;
		stall       = 1'b0;
		tk          = 0;
		cyc         = 0;
		mismatches  = 0;
		n_checks    = 0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_single_cmd();
		t_repeat_off();
		t_window();
		t_slow_lat();
		t_fast();
		t_auto();
		end_of_test();
	end
endmodule // tb_top
